// File: hdl/aopc_top.sv
// Audio output path control: registers, line-out, motor PWM and pump supply select
//
// The placing of the registers and the strobed register port were decided locally.
module aopc_top
   import aopc_pkg::*;
#(
   parameter int DECAY_CYC = DECAY_TICK_CYC,
   parameter int PWM_CYC = PWM_STEP_CYC
)(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [aopc_pkg::AW-1:0] addr_i,
   input wire logic [aopc_pkg::DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [3:0] env_level_i,
   output logic [aopc_pkg::DW-1:0] rdata_o,
   output logic [1:0] handsfree_driver_enable_o,
   output logic [1:0] motor_driver_enable_o,
   output logic [1:0] handsfree_path_enable_o,
   output logic [1:0] motor_path_enable_o,
   output logic handsfree_parallel_outputs_o,
   output logic [1:0] motor_from_regs_o,
   output logic [1:0] motor_pwm_pos_o,
   output logic [1:0] motor_pwm_neg_o,
   output logic [1:0] lineout_enable_o,
   output logic lineout_source_select_o,
   output logic [1:0] lineout_mute_o,
   output logic envelope_detect_run_o,
   output logic pump_low_supply_o,
   output logic audio_ldo_enable_o
);
   typedef struct packed
   {
      logic [3:0] drv;
      logic [4:0] path;
      logic [2:0] lo;
      logic [2:0] mute;
      logic [7:0] env;
      logic [7:0] env2;
      logic [1:0] msrc;
      logic [6:0] duty0;
      logic [6:0] duty1;
      logic ldo;
      logic [DW-1:0] rdata;
      logic [1:0] hf_drv_o;
      logic [1:0] m_drv_o;
      logic [1:0] hf_path_o;
      logic [1:0] m_path_o;
      logic par_o;
      logic [1:0] msrc_o;
      logic [1:0] lo_o;
      logic lo_src_o;
      logic [1:0] lo_mute_o;
      logic run_o;
      logic low_o;
      logic ldo_o;
      logic [31:0] dcnt;
      logic [31:0] pcnt;
      logic dtick;
      logic ptick;
   } aopc_top_st_t;

   aopc_top_st_t s_q, s_d;
   logic env_low;
   logic [1:0] pwm_pos, pwm_neg;
   logic [1:0] pwm_en;

   ////////////////////////////////////////////////////////////////
   // Register writes, dividers and output stage control
   always_comb
   begin
      s_d = s_q;
      // Slow enables for decay timing and PWM steps
      s_d.dtick = 1'b0;
      s_d.ptick = 1'b0;
      if (s_q.dcnt >= 32'(DECAY_CYC - 1))
      begin
         s_d.dcnt = 32'h0000_0000;
         s_d.dtick = 1'b1;
      end
      else
         s_d.dcnt = s_q.dcnt + 32'h0000_0001;
      if (s_q.pcnt >= 32'(PWM_CYC - 1))
      begin
         s_d.pcnt = 32'h0000_0000;
         s_d.ptick = 1'b1;
      end
      else
         s_d.pcnt = s_q.pcnt + 32'h0000_0001;
      // Software writes
      if (wr_i)
      begin
         case (addr_i)
            REG_DRV: s_d.drv = wdata_i[3:0];
            REG_PATH: s_d.path = wdata_i[4:0];
            REG_LO: s_d.lo = wdata_i[2:0];
            REG_MUTE: s_d.mute = wdata_i[2:0];
            REG_ENV: s_d.env = wdata_i;
            REG_ENV2: s_d.env2 = wdata_i;
            REG_MSRC: s_d.msrc = wdata_i[1:0];
            REG_DUTY0: s_d.duty0 = wdata_i[6:0];
            REG_DUTY1: s_d.duty1 = wdata_i[6:0];
            REG_LDO: s_d.ldo = wdata_i[0];
            default: s_d.ldo = s_q.ldo;
         endcase
      end
      // Read data stands in the cycle after the strobe only
      s_d.rdata = '0;
      if (rd_i)
      begin
         case (addr_i)
            REG_DRV: s_d.rdata = {4'h0, s_q.drv};
            REG_PATH: s_d.rdata = {3'h0, s_q.path};
            REG_LO: s_d.rdata = {5'h00, s_q.lo};
            REG_MUTE: s_d.rdata = {5'h00, s_q.mute};
            REG_ENV: s_d.rdata = s_q.env;
            REG_ENV2: s_d.rdata = s_q.env2;
            REG_MSRC: s_d.rdata = {6'h00, s_q.msrc};
            REG_DUTY0: s_d.rdata = {1'b0, s_q.duty0};
            REG_DUTY1: s_d.rdata = {1'b0, s_q.duty1};
            REG_LDO: s_d.rdata = {7'h00, s_q.ldo};
            REG_STAT: s_d.rdata = {4'h0, s_q.lo_o, s_q.run_o, s_q.low_o};
            default: s_d.rdata = '0;
         endcase
      end
      // Driver and path enables, each from its own bit
      s_d.hf_drv_o = s_q.drv[1:0];
      s_d.m_drv_o = s_q.drv[3:2];
      s_d.hf_path_o = s_q.path[1:0];
      s_d.m_path_o = s_q.path[3:2];
      // Right output follows the left channel when paralleled
      s_d.par_o = s_q.path[PATH_PAR];
      s_d.msrc_o = s_q.msrc;
      // Line-out only with both hands-free drivers off
      s_d.lo_o = (s_q.drv[DRV_HFL] || s_q.drv[DRV_HFR]) ? 2'b00 : s_q.lo[1:0];
      s_d.lo_src_o = s_q.lo[LO_SRC];
      // Mute follows the DAC that feeds each channel
      if (s_q.lo[LO_SRC])
         s_d.lo_mute_o = {2{s_q.mute[MUTE_EAR]}};
      else
         s_d.lo_mute_o = {s_q.mute[MUTE_HSR], s_q.mute[MUTE_HSL]};
      // Pump supply: AB keeps battery, class G follows envelope or manual bit
      s_d.run_o = s_q.env[ENV_EN];
      if (!s_q.env[ENV_CLASSG])
         s_d.low_o = 1'b0;
      else if (s_q.env[ENV_EN])
         s_d.low_o = env_low;
      else
         s_d.low_o = s_q.env[ENV_MAN];
      s_d.ldo_o = s_q.ldo;
   end

   ////////////////////////////////////////////////////////////////
   // State register, everything disabled at reset
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_q <= '0;
         s_q.duty0 <= RST_DUTY;
         s_q.duty1 <= RST_DUTY;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////
   // Envelope detector, running only while enabled
   aopc_envdet u_envdet (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .run_i(s_q.env[ENV_EN]),
      .tick_i(s_q.dtick),
      .level_i(env_level_i),
      .hthr_i(s_q.env[7:4]),
      .lthr_i(s_q.env2[3:0]),
      .decay_i(s_q.env2[7:4]),
      .low_o(env_low)
   );

   ////////////////////////////////////////////////////////////////
   // Motor PWM generators in register-driven mode
   assign pwm_en = s_q.msrc & s_q.drv[3:2];

   aopc_pwm u_pwm0 (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .en_i(pwm_en[0]),
      .tick_i(s_q.ptick),
      .duty_i(s_q.duty0),
      .pos_o(pwm_pos[0]),
      .neg_o(pwm_neg[0])
   );

   aopc_pwm u_pwm1 (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .en_i(pwm_en[1]),
      .tick_i(s_q.ptick),
      .duty_i(s_q.duty1),
      .pos_o(pwm_pos[1]),
      .neg_o(pwm_neg[1])
   );

   ////////////////////////////////////////////////////////////////
   // Outputs
   assign rdata_o = s_q.rdata;
   assign handsfree_driver_enable_o = s_q.hf_drv_o;
   assign motor_driver_enable_o = s_q.m_drv_o;
   assign handsfree_path_enable_o = s_q.hf_path_o;
   assign motor_path_enable_o = s_q.m_path_o;
   assign handsfree_parallel_outputs_o = s_q.par_o;
   assign motor_from_regs_o = s_q.msrc_o;
   assign motor_pwm_pos_o = pwm_pos;
   assign motor_pwm_neg_o = pwm_neg;
   assign lineout_enable_o = s_q.lo_o;
   assign lineout_source_select_o = s_q.lo_src_o;
   assign lineout_mute_o = s_q.lo_mute_o;
   assign envelope_detect_run_o = s_q.run_o;
   assign pump_low_supply_o = s_q.low_o;
   assign audio_ldo_enable_o = s_q.ldo_o;

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_lo_excl;
      @(posedge mclk_i) disable iff (!rst_b_i)
      lineout_enable_o != 2'b00 |-> handsfree_driver_enable_o == 2'b00;
   endproperty
   a_lo_excl: assert property (p_lo_excl) else $error("line-out while hands-free driven");

   property p_ab_bat;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !s_q.env[ENV_CLASSG] |=> !pump_low_supply_o;
   endproperty
   a_ab_bat: assert property (p_ab_bat) else $error("class AB left the battery ball");

   property p_manual;
      @(posedge mclk_i) disable iff (!rst_b_i)
      s_q.env[ENV_CLASSG] && !s_q.env[ENV_EN] |=> pump_low_supply_o == $past(s_q.env[ENV_MAN]);
   endproperty
   a_manual: assert property (p_manual) else $error("manual pump select ignored");

   property p_run;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && addr_i == REG_ENV ##1 1'b1 |=> envelope_detect_run_o == $past(wdata_i[ENV_EN], 2);
   endproperty
   a_run: assert property (p_run) else $error("detector run does not follow enable");

   property p_mono_mute;
      @(posedge mclk_i) disable iff (!rst_b_i)
      s_q.lo[LO_SRC] && s_q.mute[MUTE_EAR] |=> lineout_mute_o == 2'b11;
   endproperty
   a_mono_mute: assert property (p_mono_mute) else $error("mono line-out not muted");

   property p_par;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && addr_i == REG_PATH |=> ##1 handsfree_parallel_outputs_o == $past(wdata_i[PATH_PAR], 2);
   endproperty
   a_par: assert property (p_par) else $error("parallel output bit not applied");

   property p_drv;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && addr_i == REG_DRV |=> ##1 {motor_driver_enable_o, handsfree_driver_enable_o} == $past(wdata_i[3:0], 2);
   endproperty
   a_drv: assert property (p_drv) else $error("driver enables not applied");

   property p_path;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && addr_i == REG_PATH |=> ##1 {motor_path_enable_o, handsfree_path_enable_o} == $past(wdata_i[3:0], 2);
   endproperty
   a_path: assert property (p_path) else $error("path enables not applied");

   property p_msrc;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && addr_i == REG_MSRC |=> ##1 motor_from_regs_o == $past(wdata_i[1:0], 2);
   endproperty
   a_msrc: assert property (p_msrc) else $error("motor source select not applied");

   property p_pwm_idle;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !pwm_en[0] |=> !motor_pwm_pos_o[0] && !motor_pwm_neg_o[0];
   endproperty
   a_pwm_idle: assert property (p_pwm_idle) else $error("motor 0 driven while register mode is off");

   property p_lo_pass;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !s_q.drv[DRV_HFL] && !s_q.drv[DRV_HFR] |=> lineout_enable_o == $past(s_q.lo[1:0]);
   endproperty
   a_lo_pass: assert property (p_lo_pass) else $error("line-out enable not passed through");

   property p_lo_src;
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_i && addr_i == REG_LO |=> ##1 lineout_source_select_o == $past(wdata_i[LO_SRC], 2);
   endproperty
   a_lo_src: assert property (p_lo_src) else $error("line-out source select not applied");

   property p_stereo_mute;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !s_q.lo[LO_SRC] |=> lineout_mute_o[0] == $past(s_q.mute[MUTE_HSL]) && lineout_mute_o[1] == $past(s_q.mute[MUTE_HSR]);
   endproperty
   a_stereo_mute: assert property (p_stereo_mute) else $error("stereo line-out mute wrong");

   property p_env_follow;
      @(posedge mclk_i) disable iff (!rst_b_i)
      s_q.env[ENV_CLASSG] && s_q.env[ENV_EN] |=> pump_low_supply_o == $past(env_low);
   endproperty
   a_env_follow: assert property (p_env_follow) else $error("pump supply does not follow envelope");

   property p_rd_once;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !rd_i |=> rdata_o == '0;
   endproperty
   a_rd_once: assert property (p_rd_once) else $error("read data outside its cycle");
endmodule

// File: hdl/aopc_pkg.sv
// Constants, register map and types for the audio output path control block
package aopc_pkg;
   localparam int CLK_MHZ = 25;
   localparam int AW = 4;
   localparam int DW = 8;
   // Register offsets
   localparam logic [AW-1:0] REG_DRV = 4'h0;
   localparam logic [AW-1:0] REG_PATH = 4'h1;
   localparam logic [AW-1:0] REG_LO = 4'h2;
   localparam logic [AW-1:0] REG_MUTE = 4'h3;
   localparam logic [AW-1:0] REG_ENV = 4'h4;
   localparam logic [AW-1:0] REG_ENV2 = 4'h5;
   localparam logic [AW-1:0] REG_MSRC = 4'h6;
   localparam logic [AW-1:0] REG_DUTY0 = 4'h7;
   localparam logic [AW-1:0] REG_DUTY1 = 4'h8;
   localparam logic [AW-1:0] REG_LDO = 4'h9;
   localparam logic [AW-1:0] REG_STAT = 4'hA;
   // Field positions
   localparam int DRV_HFL = 0;
   localparam int DRV_HFR = 1;
   localparam int PATH_PAR = 4;
   localparam int LO_SRC = 2;
   localparam int MUTE_HSL = 0;
   localparam int MUTE_HSR = 1;
   localparam int MUTE_EAR = 2;
   localparam int ENV_EN = 0;
   localparam int ENV_MAN = 1;
   localparam int ENV_CLASSG = 2;
   // Reset values: everything disabled, pump on battery-side ball
   localparam logic [DW-1:0] RST_REG = 8'h00;
   localparam logic [6:0] RST_DUTY = 7'h32;
   // PWM and decay timing
   localparam int PWM_FULL_PCT = 100;
   localparam int PWM_STEP_NS = 1000;
   localparam int PWM_STEP_CYC = (PWM_STEP_NS * CLK_MHZ) / 1000;
   localparam int DECAY_TICK_US = 1000;
   localparam int DECAY_TICK_CYC = DECAY_TICK_US * CLK_MHZ;
   // Envelope supply state, Gray order
   typedef enum logic [0:0] {AOPC_ON_BAT = 1'b0, AOPC_ON_LOW = 1'b1} aopc_sup_t;
endpackage

// File: hdl/aopc_pwm.sv
// Register-driven complementary PWM generator for one motor output
module aopc_pwm
   import aopc_pkg::*;
#(
   parameter int STEPS = PWM_FULL_PCT
)(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic en_i,
   input wire logic tick_i,
   input wire logic [6:0] duty_i,
   output logic pos_o,
   output logic neg_o
);
   typedef struct packed
   {
      logic [6:0] cnt;
      logic pos;
      logic neg;
   } aopc_pwm_st_t;

   aopc_pwm_st_t s_q, s_d;
   logic [6:0] duty_c;

   ////////////////////////////////////////////////////////////////
   // Step counter and complementary outputs
   always_comb
   begin
      s_d = s_q;
      duty_c = (duty_i > 7'(STEPS)) ? 7'(STEPS) : duty_i;
      if (!en_i)
      begin
         s_d = '0;
      end
      else if (tick_i)
      begin
         s_d.cnt = (s_q.cnt == 7'(STEPS - 1)) ? 7'h00 : s_q.cnt + 7'h01;
         s_d.pos = (s_q.cnt < duty_c);
         s_d.neg = !(s_q.cnt < duty_c);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign pos_o = s_q.pos;
   assign neg_o = s_q.neg;

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_pwm_compl;
      @(posedge mclk_i) disable iff (!rst_b_i)
      en_i && tick_i |=> pos_o != neg_o;
   endproperty
   a_pwm_compl: assert property (p_pwm_compl) else $error("pwm shares not complementary");

   property p_pwm_zero;
      @(posedge mclk_i) disable iff (!rst_b_i)
      en_i && tick_i && duty_i == 7'h00 |=> !pos_o && neg_o;
   endproperty
   a_pwm_zero: assert property (p_pwm_zero) else $error("zero positive share drives positive");
endmodule

// File: hdl/aopc_envdet.sv
// Envelope detector selecting the negative charge pump supply ball
module aopc_envdet
   import aopc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [3:0] level_i,
   input wire logic [3:0] hthr_i,
   input wire logic [3:0] lthr_i,
   input wire logic [3:0] decay_i,
   output logic low_o
);
   typedef struct packed
   {
      aopc_sup_t sup;
      logic [3:0] cnt;
   } aopc_env_st_t;

   aopc_env_st_t s_q, s_d;

   ////////////////////////////////////////////////////////////////
   // Fast attack to battery, slow decay back to low supply
   always_comb
   begin
      s_d = s_q;
      if (!run_i)
      begin
         s_d.sup = AOPC_ON_BAT;
         s_d.cnt = 4'h0;
      end
      else if (level_i > hthr_i)
      begin
         s_d.sup = AOPC_ON_BAT;
         s_d.cnt = 4'h0;
      end
      else
      begin
         case (s_q.sup)
            AOPC_ON_BAT:
            begin
               if (level_i >= lthr_i)
                  s_d.cnt = 4'h0;
               else if (tick_i)
               begin
                  if (s_q.cnt >= decay_i)
                  begin
                     s_d.sup = AOPC_ON_LOW;
                     s_d.cnt = 4'h0;
                  end
                  else
                     s_d.cnt = s_q.cnt + 4'h1;
               end
            end
            AOPC_ON_LOW:
               s_d.cnt = 4'h0;
            default:
               s_d = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign low_o = (s_q.sup == AOPC_ON_LOW);

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_env_attack;
      @(posedge mclk_i) disable iff (!rst_b_i)
      run_i && level_i > hthr_i |=> !low_o;
   endproperty
   a_env_attack: assert property (p_env_attack) else $error("no immediate switch to battery");

   property p_env_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !low_o && !tick_i |=> !low_o;
   endproperty
   a_env_hold: assert property (p_env_hold) else $error("low supply taken without decay tick");
endmodule

// File: tb/aopc_load_model.sv
// Load model on the far side: speakers, vibra motor and line-out load
module aopc_load_model
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic [1:0] pwm_pos_i,
   input wire logic [1:0] pwm_neg_i,
   input wire logic [1:0] hf_drv_i,
   input wire logic [1:0] lo_en_i,
   output int pos_cnt_o,
   output int neg_cnt_o,
   output logic clash_o
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   // Motor 0 integrates drive time; a shorted bridge or a pin fought over by
   // two drivers is remembered until reset
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pos_cnt_o <= 0;
         neg_cnt_o <= 0;
         clash_o <= 1'b0;
      end
      else
      begin
         if (clear_i)
         begin
            pos_cnt_o <= 0;
            neg_cnt_o <= 0;
         end
         else
         begin
            pos_cnt_o <= pos_cnt_o + int'(pwm_pos_i[0]);
            neg_cnt_o <= neg_cnt_o + int'(pwm_neg_i[0]);
         end
         if ((|(pwm_pos_i & pwm_neg_i)) || ((|lo_en_i) && (|hf_drv_i)))
         begin
            clash_o <= 1'b1;
         end
      end
   end
endmodule

// File: tb/aopc_top_tb_top.sv
// Self-checking bench for the audio output path control block
module aopc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aopc_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [3:0] lvl = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   logic [1:0] hfd, mdr, hfp, mpe, mreg, ppos, pneg, loen, lomute;
   logic par, losrc, envrun, plow, ldo, clash;
   int fail_count = 0, tests_run = 0, cyc = 0, pc, nc, i;
   int dt[5] = '{0, 29, 50, 100, 120};
   ////////////////////////////////////////////////////////////////////////////
   // Clock, and a ceiling on run length
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count = fail_count + 1;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Design and load
   aopc_top #(.DECAY_CYC(4), .PWM_CYC(1)) dut (.mclk_i(mclk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .env_level_i(lvl), .rdata_o(rdata), .handsfree_driver_enable_o(hfd),
      .motor_driver_enable_o(mdr), .handsfree_path_enable_o(hfp), .motor_path_enable_o(mpe),
      .handsfree_parallel_outputs_o(par), .motor_from_regs_o(mreg), .motor_pwm_pos_o(ppos),
      .motor_pwm_neg_o(pneg), .lineout_enable_o(loen), .lineout_source_select_o(losrc),
      .lineout_mute_o(lomute), .envelope_detect_run_o(envrun), .pump_low_supply_o(plow),
      .audio_ldo_enable_o(ldo));
   aopc_load_model load (.mclk_i(mclk), .rst_b_i(rst_b), .clear_i(clr), .pwm_pos_i(ppos), .pwm_neg_i(pneg),
      .hf_drv_i(hfd), .lo_en_i(loen), .pos_cnt_o(pc), .neg_cnt_o(nc), .clash_o(clash));
   ////////////////////////////////////////////////////////////////////////////
   // Compare, bus cycles, verdict
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // One write cycle, then wait until derived outputs have settled
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   // One read cycle; data stands only in the following cycle
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk("rdata", 32'(rdata), 32'(exp));
      @(posedge mclk);
      #1;
      chk("rdata_idle", 32'(rdata), 32'h0000_0000);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      cycles(3);
      rst_b <= 1'b1;
      cycles(1);
      // Reset state and register map
      chk("outs", 32'({hfd, mdr, hfp, mpe, par, mreg, loen, losrc, lomute, envrun, plow, ldo}), 0);
      for (i = 0; i < 10; i++)
      begin
         rd_chk(4'(i), (i == 7 || i == 8) ? 8'h32 : 8'h00);
      end
      wr_reg(REG_STAT, 8'hff);
      rd_chk(REG_STAT, 8'h00);
      rd_chk(4'hb, 8'h00);
      $display("test reset done");
      // Drivers and paths each from their own bit
      wr_reg(REG_DRV, 8'h05);
      chk("drv", 32'({hfd, mdr}), 32'(4'b0101));
      wr_reg(REG_PATH, 8'h16);
      chk("path", 32'({hfp, mpe, par}), 32'(5'b1001_1));
      rd_chk(REG_PATH, 8'h16);
      $display("test drivers done");
      // Line-out held off while a hands-free driver is on
      wr_reg(REG_LO, 8'h03);
      chk("lo_blocked", 32'(loen), 0);
      wr_reg(REG_DRV, 8'h00);
      chk("lo_on", 32'(loen), 3);
      wr_reg(REG_MUTE, 8'h01);
      chk("mute_stereo", 32'({losrc, lomute}), 32'(3'b001));
      wr_reg(REG_LO, 8'h07);
      chk("mute_mono0", 32'({losrc, lomute}), 32'(3'b100));
      wr_reg(REG_MUTE, 8'h04);
      chk("mute_mono1", 32'({losrc, lomute}), 32'(3'b111));
      wr_reg(REG_DRV, 8'h01);
      chk("lo_off", 32'(loen), 0);
      $display("test lineout done");
      // Pump supply selection
      wr_reg(REG_LDO, 8'h01);
      chk("ldo", 32'(ldo), 1);
      wr_reg(REG_ENV, 8'h02);
      chk("class_ab", 32'({envrun, plow}), 32'(2'b00));
      wr_reg(REG_ENV, 8'h06);
      chk("manual", 32'({envrun, plow}), 32'(2'b01));
      lvl <= 4'ha;
      wr_reg(REG_ENV2, 8'h24);
      wr_reg(REG_ENV, 8'h85);
      cycles(2);
      chk("env_high", 32'({envrun, plow}), 32'(2'b10));
      lvl <= 4'h2;
      cycles(6);
      chk("decay_wait", 32'(plow), 0);
      for (i = 0; i < 40 && plow !== 1'b1; i++)
      begin
         cycles(1);
      end
      chk("decay_done", 32'(plow), 1);
      lvl <= 4'h9;
      cycles(3);
      chk("attack", 32'(plow), 0);
      lvl <= 4'h6;
      cycles(40);
      chk("hysteresis", 32'(plow), 0);
      $display("test pump done");
      // Register PWM on motor 0
      wr_reg(REG_DRV, 8'h0c);
      wr_reg(REG_MSRC, 8'h03);
      chk("msrc", 32'(mreg), 3);
      for (i = 0; i < 5; i++)
      begin
         wr_reg(REG_DUTY0, 8'(dt[i]));
         cycles(4);
         clr <= 1'b1;
         cycles(1);
         clr <= 1'b0;
         cycles(200);
         chk("pwm_pos", pc, (dt[i] > 100 ? 100 : dt[i]) * 2);
         chk("pwm_neg", nc, 200 - (dt[i] > 100 ? 100 : dt[i]) * 2);
      end
      wr_reg(REG_DRV, 8'h00);
      cycles(2);
      chk("pwm_off", 32'({ppos, pneg}), 0);
      chk("clash", 32'(clash), 0);
      $display("test pwm done");
      complete_run();
   end
endmodule
